//--- core/svm_pkg.sv
/*
  package of the supply monitor: register map, fields, resets, bus codes.
  assumes an ahb-lite slave with 32-bit data and word-aligned registers.
*/
// Operation
// - two-bit field picks the detector threshold
// - detector output drives event line eight
// - interrupt on falling and rising crossings
// - detection works only while enable set
// - read-only flag shows supply below threshold
// - threshold field bits 6:5, reset zero
// - enable is bit 4, reset zero
// - flag is status bit 2, reset zero
package svm_pkg;

	// ====================================================
	// register offsets
	localparam logic [7:0] SVM_CTRL_OFS = 8'h00;
	localparam logic [7:0] SVM_STAT_OFS = 8'h04;
	localparam logic [7:0] SVM_IRQ_STAT_OFS = 8'h08;
	localparam logic [7:0] SVM_IRQ_MASK_OFS = 8'h0C;
	localparam int SVM_ADDR_W = 8;

	// ====================================================
	// field positions
	localparam int SVM_SEL_LO = 5;
	localparam int SVM_SEL_HI = 6;
	localparam int SVM_EN_BIT = 4;
	localparam int SVM_FLAG_BIT = 2;
	localparam int SVM_EV_LINE = 8;
	localparam int SVM_IRQ_FALL_BIT = 0;
	localparam int SVM_IRQ_RISE_BIT = 1;
	localparam int SVM_IRQ_W = 2;

	// ====================================================
	// reset values
	localparam logic [1:0] SVM_SEL_RST = 2'h0;
	localparam logic SVM_EN_RST = 1'b0;
	localparam logic [SVM_IRQ_W-1:0] SVM_IRQ_RST = 2'h0;

	// ====================================================
	// ahb-lite codes
	localparam logic [1:0] SVM_HTRANS_NONSEQ = 2'h2;
	localparam logic [2:0] SVM_HSIZE_WORD = 3'h2;
	localparam logic SVM_HRESP_OKAY = 1'b0;

	typedef struct packed {
		logic [1:0] threshold_select;
		logic monitor_enable;
	} svm_ctrl_t;

	typedef struct packed {
		logic below;
		logic rise;
		logic fall;
	} svm_det_t;

endpackage

//--- core/svm_sync.sv
/*
  two-flop synchroniser with edge outputs taken from the second stage.
  assumes an asynchronous level input; the first flop feeds only the second.
*/
`timescale 1ns/1ps
module svm_sync (
	// clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// level in
	input wire logic async_in,
	input wire logic gate,
	// result
	output svm_pkg::svm_det_t det
);
	logic meta_r;
	logic sync_r;
	logic prev_r;

	// ====================================================
	// crossing
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			meta_r <= 1'b0;
			sync_r <= 1'b0;
		end else begin
			meta_r <= async_in;
			sync_r <= meta_r;
		end
	end

	// gated level: inactive while monitoring is off
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			prev_r <= 1'b0;
		else
			prev_r <= sync_r & gate;
	end

	always_comb begin
		det.below = prev_r;
		det.fall = (sync_r & gate) & ~prev_r;
		det.rise = ~(sync_r & gate) & prev_r & gate;
	end
endmodule

//--- core/svm_top.sv
/*
  supply voltage monitor: ahb-lite registers, threshold select, status,
  event line and a masked sticky interrupt.
  assumes one bus master, an analog comparator with an async output that is
  high while the supply is under the threshold, and an external event
  controller that applies its own edge selection to the event line.
*/
// The AHB-Lite register port and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
module svm_top (
	// clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// ahb-lite slave
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	// analog comparator
	input wire logic cmp_below_async,
	output logic [1:0] threshold_select,
	output logic monitor_enable,
	// event controller and interrupt
	output logic supply_level_detector,
	output logic irq
);
	svm_pkg::svm_ctrl_t ctrl_r;
	svm_pkg::svm_det_t det;
	logic [svm_pkg::SVM_IRQ_W-1:0] irq_stat_r;
	logic [svm_pkg::SVM_IRQ_W-1:0] irq_mask_r;
	logic [svm_pkg::SVM_IRQ_W-1:0] irq_set;
	logic wr_pend_r;
	logic stat_rd;
	logic [svm_pkg::SVM_ADDR_W-1:0] addr_r;
	logic [31:0] hrdata_r;
	logic take;

	function automatic logic hit(
		input logic [svm_pkg::SVM_ADDR_W-1:0] a,
		input logic [svm_pkg::SVM_ADDR_W-1:0] ofs
	);
		hit = (a == ofs);
	endfunction

	// ====================================================
	// bus address phase
	// zero wait states: every transfer completes in its first data cycle
	assign take = hsel && hready && (htrans == svm_pkg::SVM_HTRANS_NONSEQ);
	assign hreadyout = 1'b1;
	assign hresp = svm_pkg::SVM_HRESP_OKAY;
	assign hrdata = hrdata_r;
	// clear the status as its value is captured for the data phase
	assign stat_rd = take && !hwrite
		&& hit(haddr[svm_pkg::SVM_ADDR_W-1:0], svm_pkg::SVM_IRQ_STAT_OFS);

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pend_r <= 1'b0;
			addr_r <= '0;
		end else begin
			wr_pend_r <= take && hwrite;
			addr_r <= haddr[svm_pkg::SVM_ADDR_W-1:0];
		end
	end

	// ====================================================
	// control register
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ctrl_r.threshold_select <= svm_pkg::SVM_SEL_RST;
			ctrl_r.monitor_enable <= svm_pkg::SVM_EN_RST;
		end else if (wr_pend_r && hit(addr_r, svm_pkg::SVM_CTRL_OFS)) begin
			ctrl_r.threshold_select <=
				hwdata[svm_pkg::SVM_SEL_HI:svm_pkg::SVM_SEL_LO];
			ctrl_r.monitor_enable <= hwdata[svm_pkg::SVM_EN_BIT];
		end
	end

	assign threshold_select = ctrl_r.threshold_select;
	assign monitor_enable = ctrl_r.monitor_enable;

	// ====================================================
	// detector path
	svm_sync u_sync (
		.hclk(hclk),
		.hresetn(hresetn),
		.async_in(cmp_below_async),
		.gate(ctrl_r.monitor_enable),
		.det(det)
	);

	// the event controller sees the gated level and picks its own edges
	assign supply_level_detector = det.below;

	// ====================================================
	// interrupt status and mask
	assign irq_set = {det.rise, det.fall};

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			irq_mask_r <= svm_pkg::SVM_IRQ_RST;
		else if (wr_pend_r && hit(addr_r, svm_pkg::SVM_IRQ_MASK_OFS))
			irq_mask_r <= hwdata[svm_pkg::SVM_IRQ_W-1:0];
	end

	// an edge in the clearing read's cycle survives: set beats clear;
	// clearing at capture time means no edge is lost between the two
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			irq_stat_r <= svm_pkg::SVM_IRQ_RST;
		else if (stat_rd)
			irq_stat_r <= irq_set;
		else
			irq_stat_r <= irq_stat_r | irq_set;
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			irq <= 1'b0;
		else
			irq <= |(irq_stat_r & irq_mask_r);
	end

	// ====================================================
	// read data, registered for the data phase
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata_r <= '0;
		end else if (take && !hwrite) begin
			hrdata_r <= '0;
			unique case (haddr[svm_pkg::SVM_ADDR_W-1:0])
				svm_pkg::SVM_CTRL_OFS: begin
					hrdata_r[svm_pkg::SVM_SEL_HI:svm_pkg::SVM_SEL_LO] <=
						ctrl_r.threshold_select;
					hrdata_r[svm_pkg::SVM_EN_BIT] <= ctrl_r.monitor_enable;
				end
				svm_pkg::SVM_STAT_OFS: begin
					hrdata_r[svm_pkg::SVM_FLAG_BIT] <= det.below;
				end
				svm_pkg::SVM_IRQ_STAT_OFS: begin
					hrdata_r[svm_pkg::SVM_IRQ_W-1:0] <= irq_stat_r;
				end
				svm_pkg::SVM_IRQ_MASK_OFS: begin
					hrdata_r[svm_pkg::SVM_IRQ_W-1:0] <= irq_mask_r;
				end
				default: begin
					hrdata_r <= '0;
				end
			endcase
		end
	end
endmodule

//--- test/svm_asserts.sv
/* checker of the supply monitor ports
   assumes the single clock and reset of svm_top */
`timescale 1ns/1ps
module svm_asserts (
	// clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// bus
	input wire logic hsel,
	input wire logic hwrite,
	input wire logic [1:0] htrans,
	input wire logic hreadyout,
	input wire logic hresp,
	// monitor
	input wire logic cmp_below_async,
	input wire logic [1:0] threshold_select,
	input wire logic monitor_enable,
	input wire logic supply_level_detector,
	input wire logic irq
);
	wire wr_ok = hsel && hwrite && htrans == svm_pkg::SVM_HTRANS_NONSEQ;
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);
	// ====
	// comparator high for the whole synchroniser depth
	sequence below_held;
		(cmp_below_async && monitor_enable)[*4];
	endsequence
	a_bus_okay: assert property (hreadyout && !hresp)
		else $error("bus wait or error");
	a_rst_zero: assert property ($rose(hresetn) |->
		{threshold_select, monitor_enable, supply_level_detector, irq} == 5'h00)
		else $error("outputs not clear after reset");
	a_cfg_write: assert property (
		$changed({threshold_select, monitor_enable}) |-> $past(wr_ok, 2))
		else $error("control changed without write");
	a_det_high: assert property (below_held |-> supply_level_detector)
		else $error("line low while below");
	a_det_low: assert property (
		(!cmp_below_async)[*4] |-> !supply_level_detector)
		else $error("line high while above");
	a_off_quiet: assert property (
		!monitor_enable |=> !supply_level_detector)
		else $error("line high while disabled");
	a_det_lag: assert property (
		$rose(supply_level_detector) |-> $past(cmp_below_async, 3))
		else $error("line rose without comparator");
	a_irq_cause: assert property ($rose(irq) |->
		$past(supply_level_detector, 1) != $past(supply_level_detector, 2)
		|| $past(wr_ok, 3))
		else $error("irq rose without cause");
endmodule
bind svm_top svm_asserts i_chk (.*);

//--- test/svm_cmp_model.sv
/* comparator model: supply code against threshold code
   assumes the bench drives the supply code */
`timescale 1ns/1ps
module svm_cmp_model #(parameter int DLY = 7) (
	// inputs
	input wire logic [2:0] supply,
	input wire logic [1:0] sel,
	// comparator out
	output logic below
);
	// delay keeps the level off the clock edge, as a real async input
	assign #DLY below = (supply <= {1'b0, sel});
endmodule

//--- test/tb.sv
/* self-checking bench of svm_top
   assumes the comparator model and the bound checker */
`timescale 1ns/1ps
module tb;
	logic hclk, hresetn, hsel, hwrite, rd_ph, hreadyout, cmp, en, sld, irq;
	logic [1:0] htrans, sel;
	logic [31:0] haddr, hwdata, hrdata;
	logic [2:0] supply;
	logic [7:0] rs;
	logic [31:0] q[$];
	int failures, check_count, cyc;
	svm_top i_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
		.hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hresp(),
		.hreadyout(hreadyout), .cmp_below_async(cmp), .irq(irq),
		.threshold_select(sel), .monitor_enable(en),
		.supply_level_detector(sld));
	svm_cmp_model i_cmp (.supply(supply), .sel(sel), .below(cmp));
	// ====
	function automatic logic [7:0] lfsr(input logic [7:0] s);
		return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
	endfunction
	task automatic cmp_val(input string n, input logic [31:0] e, g);
		check_count++;
		if (g !== e) begin
			failures++;
			$display("ERROR %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic cmp_bit(input string n, input logic e, input logic g);
		check_count++;
		if (g !== e) begin
			failures++;
			$display("ERROR %s expected %b seen %b", n, e, g);
		end
	endtask
	task automatic complete_run;
		$display("checks %0d failures %0d", check_count, failures);
		if (failures == 0 && check_count > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		hsel <= 1'b1;
		htrans <= 2'h2;
		hwrite <= w;
		haddr <= {24'h0, a};
		@(posedge hclk);
		while (hreadyout !== 1'b1) @(posedge hclk);
		htrans <= 2'h0;
		hwdata <= d;
		rd_ph <= !w;
		@(posedge hclk);
		while (hreadyout !== 1'b1) @(posedge hclk);
		rd_ph <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		q.push_back(e);
		bus(1'b0, a, 32'h0);
	endtask
	task automatic wt;
		repeat (8) @(posedge hclk);
	endtask
	// ====
	always @(posedge hclk) begin
		if (rd_ph && hreadyout)
			cmp_val("hrdata", q.pop_front(), hrdata);
	end
	always @(posedge hclk) begin
		cyc++;
		if (cyc == 3000) begin
			failures++;
			complete_run;
		end
	end
	initial begin
		{hclk, hresetn, hsel, hwrite, rd_ph, htrans, haddr, hwdata} = '0;
		supply = 3'h7;
		rs = 8'h3C;
		forever #20 hclk = ~hclk;
	end
	initial begin
		repeat (8) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		rd(8'h00, 32'h0);
		rd(8'h04, 32'h0);
		rd(8'h10, 32'h0);
		bus(1'b1, 8'h0C, 32'h3);
		bus(1'b1, 8'h00, 32'h70);
		supply <= 3'h0;
		wt;
		cmp_bit("irq", 1'b1, irq);
		rd(8'h08, 32'h1);
		supply <= 3'h7;
		wt;
		rd(8'h08, 32'h2);
		bus(1'b1, 8'h0C, 32'h0);
		supply <= 3'h0;
		wt;
		cmp_bit("irq", 1'b0, irq);
		rd(8'h08, 32'h1);
		for (int i = 0; i < 12; i++) begin
			logic below_e;
			rs = lfsr(rs);
			below_e = rs[2:0] <= {1'b0, rs[4:3]};
			bus(1'b1, 8'h00, {25'h0, rs[4:3], 5'h10});
			supply <= rs[2:0];
			wt;
			rd(8'h00, {25'h0, rs[4:3], 5'h10});
			rd(8'h04, {29'h0, below_e, 2'h0});
			cmp_bit("line", below_e, sld);
			cmp_val("select", {30'h0, rs[4:3]}, {30'h0, sel});
			cmp_bit("enable", 1'b1, en);
		end
		supply <= 3'h0;
		bus(1'b1, 8'h00, 32'h60);
		wt;
		rd(8'h04, 32'h0);
		cmp_bit("line", 1'b0, sld);
		cmp_bit("enable", 1'b0, en);
		complete_run;
	end
endmodule
